// ---- core/ufe_endpoint.sv ----
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

// What this block does
// [R1] each event flag stays set until software writes one to it
// [R2] flags never clear when the raising condition goes away
// [R3] writing zero to a flag bit leaves it unchanged
// [R4] event in same cycle as clearing write keeps the flag set
// [R5] every monitored event can raise the processor interrupt
// [R6] flag bits 31 to 9 hold no state and read zero
// [R7] bit 8 sets when the fifo becomes full
// [R8] bit 7 sets when the fifo becomes empty
// [R9] bit 6 sets on fifo controller error; cause kept in condition register
// [R10] bit 5 sets when byte count rises above high alarm
// [R11] bit 4 sets when byte count falls below low alarm
// [R12] bit 3 sets on control endpoint setup while request flag pending
// [R13] bit 2 sets on last packet; short packet counts as last
// [R14] control endpoints also end transfer after wlength bytes moved
// [R15] bit 1 sets on device request, control endpoints only
// [R16] bit 0 sets on every packet end between fifo and core
// [R17] mask bit one blocks its flag from the interrupt
// [R18] mask bit zero lets its flag interrupt again
// [R19] data port read pops receive data, write pushes transmit data
// [R20] data port works whatever the fifo direction
// [R21] data port accepts byte, halfword and word accesses
// [R22] software uses base offset; byte 1..3 and halfword 2 accepted
// [R23] overflow and underflow are sticky, cleared by writing one
// [R24] interrupt high while any flag set with its mask bit zero
module ufe_endpoint
(
    input wire logic mclk,
    input wire logic resetn,
    input wire ufe_pkg::ufe_bus_req_t bus_req,
    output logic [ufe_pkg::DATA_W-1:0] bus_rdata,
    input wire ufe_pkg::ufe_core_evt_t core_evt,
    input wire ufe_pkg::ufe_fifo_stat_t fifo_stat,
    input wire logic [ufe_pkg::DATA_W-1:0] rx_data,
    output ufe_pkg::ufe_fifo_xfer_t rx_pop,
    output ufe_pkg::ufe_fifo_xfer_t tx_push,
    output logic irq
);

    import ufe_pkg::*;

    // ==================================================
    // reset release
    logic rst_meta;
    logic rst_n;

    // assertion is immediate, release waits two edges
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ==================================================
    // helpers
    function automatic logic [2:0] size_bytes(input ufe_size_t sz);
        unique case (sz)
            SZ_BYTE: return 3'h1;
            SZ_HALF: return 3'h2;
            SZ_WORD: return 3'h4;
            default: return 3'h0;
        endcase
    endfunction

    // left-justified mask of the bytes an access carries
    function automatic logic [DATA_W-1:0] top_mask(input ufe_size_t sz);
        unique case (sz)
            SZ_BYTE: return 32'hff00_0000;
            SZ_HALF: return 32'hffff_0000;
            SZ_WORD: return 32'hffff_ffff;
            default: return 32'h0000_0000;
        endcase
    endfunction

    // [R22] legal lane offsets
    function automatic logic lane_ok(input ufe_size_t sz, input logic [1:0] off);
        unique case (sz)
            SZ_BYTE: return 1'b1;
            SZ_HALF: return (off == 2'h0) || (off == 2'h2);
            SZ_WORD: return (off == 2'h0);
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [4:0] lane_shift(input logic [1:0] off);
        return {off, 3'h0};
    endfunction

    // sizes double per code step: 8, 16, 32, 64
    function automatic logic [PKT_W-1:0] max_pkt(input logic [1:0] code);
        return PKT_W'(7'h08 << code);
    endfunction

    // ==================================================
    // bus decode
    logic [ADDR_W-1:0] word_addr;
    logic [1:0] byte_off;
    logic wr_flags;
    logic wr_mask;
    logic wr_cond;
    logic wr_ctrl;
    logic wr_alarm;
    logic fifo_access_ok;

    assign word_addr = bus_req.addr & WORD_MASK;
    assign byte_off = bus_req.addr[1:0];
    assign wr_flags = bus_req.wr && (word_addr == OFF_FLAGS);
    assign wr_mask = bus_req.wr && (word_addr == OFF_MASK);
    assign wr_cond = bus_req.wr && (word_addr == OFF_COND);
    assign wr_ctrl = bus_req.wr && (word_addr == OFF_CTRL);
    assign wr_alarm = bus_req.wr && (word_addr == OFF_ALARM);
    assign fifo_access_ok = (word_addr == OFF_FIFO) && lane_ok(bus_req.size, byte_off);

    // ==================================================
    // software-set registers
    logic [FLAG_W-1:0] mask;
    logic ctrl_ep;
    logic [1:0] max_code;
    logic [CNT_W-1:0] low_level;
    logic [CNT_W-1:0] high_level;

    // [R17] [R18] mask write
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            mask <= MASK_RST;
        else if (wr_mask)
            mask <= bus_req.wdata[FLAG_W-1:0];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ep <= CTRL_RST[CTRL_EP_POS];
            max_code <= CTRL_RST[CTRL_MAX_LSB +: 2];
        end
        else if (wr_ctrl)
        begin
            ctrl_ep <= bus_req.wdata[CTRL_EP_POS];
            max_code <= bus_req.wdata[CTRL_MAX_LSB +: 2];
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_level <= LOW_RST;
            high_level <= HIGH_RST;
        end
        else if (wr_alarm)
        begin
            low_level <= bus_req.wdata[ALARM_LOW_LSB +: CNT_W];
            high_level <= bus_req.wdata[ALARM_HIGH_LSB +: CNT_W];
        end
    end

    // ==================================================
    // fifo condition edges
    logic full_d;
    logic empty_d;
    logic above_d;
    logic below_d;
    logic above_now;
    logic below_now;

    assign above_now = fifo_stat.count > high_level;
    assign below_now = fifo_stat.count < low_level;

    // history starts as "already true" so reset itself raises nothing
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            full_d <= 1'b1;
            empty_d <= 1'b1;
            above_d <= 1'b1;
            below_d <= 1'b1;
        end
        else
        begin
            full_d <= fifo_stat.full;
            empty_d <= fifo_stat.empty;
            above_d <= above_now;
            below_d <= below_now;
        end
    end

    // ==================================================
    // fifo error causes
    logic [COND_W-1:0] cond;
    logic [COND_W-1:0] cond_set;
    logic [COND_W-1:0] cond_clr;

    assign cond_set[COND_OVF] = fifo_stat.overflow;
    assign cond_set[COND_UNF] = fifo_stat.underflow;
    assign cond_clr[COND_OVF] = bus_req.wdata[COND_OVF_POS];
    assign cond_clr[COND_UNF] = bus_req.wdata[COND_UNF_POS];

    // [R23] sticky error causes
    ufe_sticky #(
        .W(COND_W),
        .RST('0)
    ) u_cond (
        .clk(mclk),
        .rst_n(rst_n),
        .set(cond_set),
        .clr_wr(wr_cond),
        .clr_bits(cond_clr),
        .q(cond)
    );

    // ==================================================
    // transfer end tracking
    logic xfer_end;

    ufe_xfer_track u_track (
        .clk(mclk),
        .rst_n(rst_n),
        .ctrl_ep(ctrl_ep),
        .max_bytes(max_pkt(max_code)),
        .evt(core_evt),
        .xfer_end(xfer_end)
    );

    // ==================================================
    // event flags
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] flag_set;

    always_comb
    begin
        flag_set = '0;
        // [R7] full edge
        flag_set[BIT_FULL] = fifo_stat.full && !full_d;
        // [R8] empty edge
        flag_set[BIT_EMPTY] = fifo_stat.empty && !empty_d;
        // [R9] controller error
        flag_set[BIT_ERR] = fifo_stat.overflow || fifo_stat.underflow;
        // [R10] count rose above high
        flag_set[BIT_HIGH] = above_now && !above_d;
        // [R11] count fell below low
        flag_set[BIT_LOW] = below_now && !below_d;
        // [R12] setup on pending request
        flag_set[BIT_MSETUP] = core_evt.setup_rcvd && ctrl_ep && flags[BIT_REQ];
        // [R13] [R14] transfer end
        flag_set[BIT_XEND] = xfer_end;
        // [R15] request on control endpoint
        flag_set[BIT_REQ] = core_evt.setup_rcvd && ctrl_ep;
        // [R16] packet end marker
        flag_set[BIT_EOF] = core_evt.pkt_end;
    end

    // [R1] [R2] [R4] only software clears
    ufe_sticky #(
        .W(FLAG_W),
        .RST(FLAGS_RST)
    ) u_flags (
        .clk(mclk),
        .rst_n(rst_n),
        .set(flag_set),
        .clr_wr(wr_flags),
        .clr_bits(bus_req.wdata[FLAG_W-1:0]),
        .q(flags)
    );

    // ==================================================
    // interrupt
    // [R5] [R24] unmasked flags drive irq
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(flags & ~mask);
    end

    // ==================================================
    // data port
    logic [DATA_W-1:0] wr_just;

    // bring the written lane up to the top byte, first byte out first
    assign wr_just = (bus_req.wdata << lane_shift(byte_off)) & top_mask(bus_req.size);

    // [R19] [R20] [R21] write pushes
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tx_push <= '0;
        else
        begin
            tx_push.strobe <= bus_req.wr && fifo_access_ok;
            tx_push.bytes <= size_bytes(bus_req.size);
            tx_push.data <= wr_just;
        end
    end

    // [R19] [R20] [R21] read pops
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rx_pop <= '0;
        else
        begin
            rx_pop.strobe <= bus_req.rd && fifo_access_ok;
            rx_pop.bytes <= size_bytes(bus_req.size);
            rx_pop.data <= rx_data & top_mask(bus_req.size);
        end
    end

    // ==================================================
    // read data
    logic [DATA_W-1:0] next_rdata;

    always_comb
    begin
        next_rdata = '0;
        unique case (word_addr)
            // [R6] upper bits read zero
            OFF_FLAGS: next_rdata[FLAG_W-1:0] = flags;
            OFF_MASK: next_rdata[FLAG_W-1:0] = mask;
            OFF_FIFO:
            begin
                // misaligned sizes return zero and pop nothing
                if (fifo_access_ok)
                    next_rdata = (rx_data & top_mask(bus_req.size)) >> lane_shift(byte_off);
            end
            OFF_COND:
            begin
                next_rdata[COND_OVF_POS] = cond[COND_OVF];
                next_rdata[COND_UNF_POS] = cond[COND_UNF];
                next_rdata[COND_FULL_POS] = fifo_stat.full;
            end
            OFF_CTRL:
            begin
                next_rdata[CTRL_EP_POS] = ctrl_ep;
                next_rdata[CTRL_MAX_LSB +: 2] = max_code;
            end
            OFF_ALARM:
            begin
                next_rdata[ALARM_LOW_LSB +: CNT_W] = low_level;
                next_rdata[ALARM_HIGH_LSB +: CNT_W] = high_level;
            end
            default: next_rdata = '0;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            bus_rdata <= '0;
        else if (bus_req.rd)
            bus_rdata <= next_rdata;
        else
            bus_rdata <= '0;
    end

endmodule

// ---- core/ufe_pkg.sv ----
package ufe_pkg;

    // ==================================================
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 9;
    localparam int CNT_W = 12;
    localparam int PKT_W = 7;
    localparam int LEN_W = 16;

    // ==================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_FIFO = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COND = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ALARM = 8'h14;
    localparam logic [ADDR_W-1:0] WORD_MASK = 8'hfc;

    // ==================================================
    // event flag bit positions
    localparam int BIT_EOF = 0;
    localparam int BIT_REQ = 1;
    localparam int BIT_XEND = 2;
    localparam int BIT_MSETUP = 3;
    localparam int BIT_LOW = 4;
    localparam int BIT_HIGH = 5;
    localparam int BIT_ERR = 6;
    localparam int BIT_EMPTY = 7;
    localparam int BIT_FULL = 8;

    // ==================================================
    // fifo condition register fields
    localparam int COND_W = 2;
    localparam int COND_OVF = 0;
    localparam int COND_UNF = 1;
    localparam int COND_FULL_POS = 18;
    localparam int COND_OVF_POS = 20;
    localparam int COND_UNF_POS = 21;

    // ==================================================
    // control and alarm fields
    localparam int CTRL_EP_POS = 0;
    localparam int CTRL_MAX_LSB = 1;
    localparam int ALARM_LOW_LSB = 0;
    localparam int ALARM_HIGH_LSB = 16;

    // ==================================================
    // reset values
    localparam logic [FLAG_W-1:0] FLAGS_RST = 9'h000;
    localparam logic [FLAG_W-1:0] MASK_RST = 9'h000;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [CNT_W-1:0] LOW_RST = 12'h000;
    localparam logic [CNT_W-1:0] HIGH_RST = 12'hfff;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } ufe_size_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        ufe_size_t size;
        logic wr;
        logic rd;
    } ufe_bus_req_t;

    typedef struct packed {
        logic pkt_end;
        logic [PKT_W-1:0] pkt_bytes;
        logic setup_rcvd;
        logic [LEN_W-1:0] wlength;
    } ufe_core_evt_t;

    typedef struct packed {
        logic full;
        logic empty;
        logic [CNT_W-1:0] count;
        logic overflow;
        logic underflow;
    } ufe_fifo_stat_t;

    typedef struct packed {
        logic strobe;
        logic [2:0] bytes;
        logic [DATA_W-1:0] data;
    } ufe_fifo_xfer_t;

endpackage

// ---- core/ufe_sticky.sv ----
`timescale 1ns/1ps

module ufe_sticky #(
    parameter int W = 9,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] set,
    input wire logic clr_wr,
    input wire logic [W-1:0] clr_bits,
    output logic [W-1:0] q
);

    logic [W-1:0] next_q;

    always_comb
    begin
        // [R3] zero leaves bit
        next_q = clr_wr ? (q & ~clr_bits) : q;
        // [R4] set beats clear
        next_q = next_q | set;
    end

    // [R1] sticky until one written
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= RST;
        else
            q <= next_q;
    end

endmodule

// ---- core/ufe_xfer_track.sv ----
`timescale 1ns/1ps

module ufe_xfer_track
    import ufe_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctrl_ep,
    input wire logic [PKT_W-1:0] max_bytes,
    input wire ufe_pkg::ufe_core_evt_t evt,
    output logic xfer_end
);

    logic active;
    logic [LEN_W-1:0] remaining;
    logic short_pkt;
    logic len_done;

    // [R13] short packet ends transfer
    assign short_pkt = evt.pkt_bytes < max_bytes;
    // [R14] wlength bytes moved
    assign len_done = active && ({{(LEN_W-PKT_W){1'b0}}, evt.pkt_bytes} >= remaining);
    assign xfer_end = evt.pkt_end && (short_pkt || len_done);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active <= 1'b0;
            remaining <= '0;
        end
        else if (evt.setup_rcvd)
        begin
            // zero-length data stage has nothing to count
            active <= ctrl_ep && (evt.wlength != '0);
            remaining <= evt.wlength;
        end
        else if (evt.pkt_end && active)
        begin
            active <= !len_done;
            remaining <= remaining - {{(LEN_W-PKT_W){1'b0}}, evt.pkt_bytes};
        end
    end

endmodule

// ---- sim/ufe_checker.sv ----
`timescale 1ns/1ps

module ufe_checker
    import ufe_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire ufe_pkg::ufe_bus_req_t bus_req,
    input wire logic [ufe_pkg::DATA_W-1:0] bus_rdata,
    input wire ufe_pkg::ufe_core_evt_t core_evt,
    input wire ufe_pkg::ufe_fifo_stat_t fifo_stat,
    input wire logic [ufe_pkg::DATA_W-1:0] rx_data,
    input wire ufe_pkg::ufe_fifo_xfer_t rx_pop,
    input wire ufe_pkg::ufe_fifo_xfer_t tx_push,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // ========================================
    // helpers
    // mask shadow; writes at the aligned mask address only, as the bench never masks by byte
    logic [FLAG_W-1:0] mask_m;
    logic fifo_rd;
    assign fifo_rd = bus_req.rd && (bus_req.addr & WORD_MASK) == OFF_FIFO;
    always_ff @(posedge mclk or negedge resetn)
        if (!resetn)
            mask_m <= MASK_RST;
        else if (bus_req.wr && bus_req.addr == OFF_MASK)
            mask_m <= bus_req.wdata[FLAG_W-1:0];

    // ========================================
    // data port
    chk_rdata_idle:
    assert property (!bus_req.rd |=> bus_rdata == '0) else $error("read data outside slot");
    chk_word_pop:
    assert property (fifo_rd && bus_req.addr == OFF_FIFO && bus_req.size == SZ_WORD
        |=> rx_pop.strobe && rx_pop.bytes == 3'h4 && bus_rdata == $past(rx_data))
        else $error("word read of fifo wrong");
    chk_word_push:
    assert property (bus_req.wr && bus_req.addr == OFF_FIFO && bus_req.size == SZ_WORD
        |=> tx_push.strobe && tx_push.bytes == 3'h4 && tx_push.data == $past(bus_req.wdata))
        else $error("word write of fifo wrong");
    chk_byte_pop:
    assert property (fifo_rd && bus_req.size == SZ_BYTE |=> rx_pop.strobe && rx_pop.bytes == 3'h1)
        else $error("byte read did not pop one byte");
    chk_no_pop:
    assert property (!fifo_rd |=> !rx_pop.strobe) else $error("pop without fifo read");
    chk_half_refused:
    assert property (bus_req.wr && bus_req.addr == OFF_FIFO + 8'h01 && bus_req.size == SZ_HALF
        |=> !tx_push.strobe) else $error("odd halfword write pushed");

    // ========================================
    // interrupt
    chk_irq_raise:
    assert property (core_evt.pkt_end && !mask_m[BIT_EOF] && !bus_req.wr ##1 !bus_req.wr
        |=> irq) else $error("unmasked event gave no interrupt");
    chk_irq_masked:
    assert property (mask_m == 9'h1ff |=> !irq) else $error("interrupt while all masked");
    chk_irq_holds:
    assert property (irq && !bus_req.wr && !$past(bus_req.wr) |=> irq)
        else $error("interrupt dropped without a write");

    cov_irq: cover property ($rose(irq));
    cov_byte_push: cover property (tx_push.strobe && tx_push.bytes == 3'h1);
    cov_half_pop: cover property (rx_pop.strobe && rx_pop.bytes == 3'h2);
endmodule

bind ufe_endpoint ufe_checker chk (.mclk(mclk), .resetn(resetn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .core_evt(core_evt), .fifo_stat(fifo_stat), .rx_data(rx_data),
    .rx_pop(rx_pop), .tx_push(tx_push), .irq(irq));

// ---- sim/ufe_far_model.sv ----
`timescale 1ns/1ps

module ufe_far_model
    import ufe_pkg::*;
#(
    parameter int DEPTH = 64
)
(
    input wire logic mclk,
    input wire ufe_pkg::ufe_fifo_xfer_t rx_pop,
    output ufe_pkg::ufe_core_evt_t core_evt,
    output ufe_pkg::ufe_fifo_stat_t fifo_stat,
    output logic [ufe_pkg::DATA_W-1:0] rx_data
);
    // ========================================
    // receive fifo; transmit side is judged at the port only
    logic [7:0] q[$];
    logic [7:0] seq;
    logic [7:0] pad;
    logic [DATA_W-1:0] head;

    initial
    begin
        core_evt = '0;
        fifo_stat = '0;
        fifo_stat.empty = 1'b1;
        rx_data = '0;
        seq = 8'h00;
        pad = 8'h5a;
    end

    always @(posedge mclk)
    begin
        if (rx_pop.strobe)
            repeat (rx_pop.bytes)
                void'(q.pop_front());
        if (core_evt.pkt_end)
            repeat (core_evt.pkt_bytes)
            begin
                q.push_back(seq);
                seq = seq + 8'h01;
            end
        // empty lanes toggle so a stale byte never passes for data
        pad = ~pad;
        for (int i = 0; i < 4; i++)
            head[31 - 8 * i -: 8] = i < q.size() ? q[i] : pad;
        rx_data <= head;
        fifo_stat.count <= CNT_W'(q.size());
        fifo_stat.full <= q.size() >= DEPTH;
        fifo_stat.empty <= q.size() == 0;
    end

    task automatic pkt(input int n);
        @(posedge mclk);
        core_evt.pkt_end <= 1'b1;
        core_evt.pkt_bytes <= PKT_W'(n);
        @(posedge mclk);
        core_evt.pkt_end <= 1'b0;
        core_evt.pkt_bytes <= ~PKT_W'(n);
    endtask

    task automatic setup(input logic [LEN_W-1:0] len);
        @(posedge mclk);
        core_evt.setup_rcvd <= 1'b1;
        core_evt.wlength <= len;
        @(posedge mclk);
        core_evt.setup_rcvd <= 1'b0;
        core_evt.wlength <= ~len;
    endtask

    task automatic err(input logic under);
        @(posedge mclk);
        {fifo_stat.underflow, fifo_stat.overflow} <= {under, !under};
        @(posedge mclk);
        {fifo_stat.underflow, fifo_stat.overflow} <= 2'h0;
    endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps

module testbench;
    import ufe_pkg::*;

    typedef struct {
        int kind;
        logic [FLAG_W-1:0] exp;
    } ufe_row_t;

    logic mclk;
    logic resetn;
    ufe_bus_req_t bus_req;
    logic [DATA_W-1:0] bus_rdata;
    ufe_core_evt_t core_evt;
    ufe_fifo_stat_t fifo_stat;
    logic [DATA_W-1:0] rx_data;
    ufe_fifo_xfer_t rx_pop;
    ufe_fifo_xfer_t tx_push;
    logic irq;
    logic [DATA_W-1:0] d;
    logic [7:0] hd = 8'h00;
    int bad_count = 0;
    int checked = 0;
    // event kind beside the flags it alone must leave set
    ufe_row_t rows [7] = '{'{0, 9'h001}, '{1, 9'h005}, '{2, 9'h002}, '{3, 9'h00a},
        '{4, 9'h040}, '{5, 9'h040}, '{6, 9'h007}};
    int acc [7][2] = '{'{0, 1}, '{1, 1}, '{2, 1}, '{3, 1}, '{0, 2}, '{2, 2}, '{0, 4}};

    ufe_endpoint dut (.mclk(mclk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .core_evt(core_evt), .fifo_stat(fifo_stat), .rx_data(rx_data), .rx_pop(rx_pop),
        .tx_push(tx_push), .irq(irq));
    ufe_far_model #(.DEPTH(40)) far (.mclk(mclk), .rx_pop(rx_pop), .core_evt(core_evt),
        .fifo_stat(fifo_stat), .rx_data(rx_data));

    // ========================================
    // bus and compare tasks
    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    function automatic ufe_size_t sz(input int n);
        return n == 4 ? SZ_WORD : n == 2 ? SZ_HALF : SZ_BYTE;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input ufe_size_t s = SZ_WORD);
        @(posedge mclk);
        bus_req <= '{a, v, s, 1'b1, 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, input ufe_size_t s = SZ_WORD);
        @(posedge mclk);
        bus_req <= '{a, 32'h0, s, 1'b0, 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 v = bus_rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        chk("register", 36'(e), 36'(d));
    endtask

    // expected lanes follow the big-endian port layout
    task automatic pop(input int off, input int n);
        logic [31:0] v;
        v = {hd, hd + 8'h01, hd + 8'h02, hd + 8'h03};
        v = (v >> (8 * (4 - n))) << (8 * (4 - n - off));
        rd(OFF_FIFO + 8'(off), d, sz(n));
        chk("fifo read", 36'(v), 36'(d));
        hd = hd + 8'(n);
    endtask

    task automatic push(input int off, input int n);
        logic [31:0] v;
        v = ((32'h11223344 << (8 * off)) >> (8 * (4 - n))) << (8 * (4 - n));
        wr(OFF_FIFO + 8'(off), 32'h11223344, sz(n));
        #1 chk("fifo push", {1'b1, 3'(n), v}, {tx_push.strobe, tx_push.bytes, tx_push.data});
    endtask

    task automatic ev(input int k);
        case (k)
            0: far.pkt(8);
            1: far.pkt(3);
            2: far.setup(16'h0000);
            3:
            begin
                far.setup(16'h0000);
                far.setup(16'h0000);
            end
            4: far.err(1'b0);
            5: far.err(1'b1);
            default:
            begin
                far.setup(16'h0010);
                far.pkt(8);
                far.pkt(8);
            end
        endcase
    endtask

    // ========================================
    // clock, watchdog, sequence
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        finish_test();
    end

    initial
    begin
        resetn = 1'b0;
        bus_req = '0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        rchk(OFF_FLAGS, 32'h0);
        rchk(OFF_MASK, 32'h0);
        wr(8'h18, 32'hffffffff);
        rchk(8'h18, 32'h0);
        wr(OFF_CTRL, 32'h1);
        foreach (rows[i])
        begin
            wr(OFF_FLAGS, 32'h1ff);
            tick(2);
            chk("irq", 36'h0, 36'(irq));
            ev(rows[i].kind);
            rchk(OFF_FLAGS, 32'(rows[i].exp));
            chk("irq", 36'h1, 36'(irq));
        end
        wr(OFF_FLAGS, 32'h0);
        rchk(OFF_FLAGS, 32'h7);
        wr(OFF_FLAGS, 32'h1);
        rchk(OFF_FLAGS, 32'h6);
        rchk(OFF_COND, 32'h00300000);
        wr(OFF_COND, 32'h00100000);
        rchk(OFF_COND, 32'h00200000);
        fork
            far.pkt(8);
            wr(OFF_FLAGS, 32'h1ff);
        join
        rchk(OFF_FLAGS, 32'h1);
        wr(OFF_MASK, 32'hffffffff);
        tick(1);
        chk("irq", 36'h0, 36'(irq));
        rchk(OFF_MASK, 32'h1ff);
        wr(OFF_MASK, 32'h0);
        tick(1);
        chk("irq", 36'h1, 36'(irq));
        foreach (acc[i])
        begin
            pop(acc[i][0], acc[i][1]);
            push(acc[i][0], acc[i][1]);
        end
        rd(OFF_FIFO + 8'h01, d, SZ_HALF);
        chk("odd halfword read", 36'h0, 36'(d));
        wr(OFF_FIFO + 8'h01, 32'h11223344, SZ_HALF);
        #1 chk("odd halfword push", 36'h0, 36'(tx_push.strobe));
        // level events: 23 bytes held, low 4, high 30, full at 40
        wr(OFF_ALARM, 32'h001e0004);
        wr(OFF_FLAGS, 32'h1ff);
        repeat (3) far.pkt(8);
        repeat (11) pop(0, 4);
        repeat (3) pop(0, 1);
        // empty shows two edges after the last pop strobe
        tick(2);
        rchk(OFF_FLAGS, 32'h1b1);
        // bulk endpoint, 64-byte packets: no request, 16 bytes is short
        wr(OFF_CTRL, 32'h6);
        rchk(OFF_CTRL, 32'h6);
        wr(OFF_FLAGS, 32'h1ff);
        far.setup(16'h0010);
        far.pkt(16);
        rchk(OFF_FLAGS, 32'h5);
        finish_test();
    end
endmodule
